// file: efh_buf.sv
// Parameterised word FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module efh_buf #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  efh_stream_if.snk in_s,
  efh_stream_if.src out_s
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULLC = CW'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic full_r, full_nxt, empty_r, empty_nxt;
  logic push, pop;

  assign in_s.ready = !full_r;
  assign out_s.valid = !empty_r;
  assign out_s.data = mem_r[rd_ptr_r];
  assign push = in_s.valid && !full_r;
  assign pop = out_s.ready && !empty_r;

  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wr_ptr_nxt = (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
    end
    if (pop) begin
      rd_ptr_nxt = (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    full_nxt = (cnt_nxt == FULLC);
    empty_nxt = (cnt_nxt == '0);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      full_r <= 1'b0;
      empty_r <= 1'b1;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r <= cnt_nxt;
      full_r <= full_nxt;
      empty_r <= empty_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_s.data;
    end
  end

  // Count stays within depth and tracks flags
  property p_buf_count;
    @(posedge sys_clk) disable iff (!resetn)
      (cnt_r <= FULLC) && (full_r == (cnt_r == FULLC)) && (empty_r == (cnt_r == '0));
  endproperty
  a_buf_count: assert property (p_buf_count) else $error("FIFO count and flags disagree");
endmodule : efh_buf
`default_nettype wire

// file: efh_dev_model.sv
// Behavioural model of the external sixteen-word elastic store.
// Assumes pins change only after sys_clk edges; slow lengthens the ripple.
`timescale 1ns/1ns
`default_nettype none
module efh_dev_model (
  input wire logic sys_clk,
  input wire logic master_clear,
  input wire logic shift_in,
  input wire logic [efh_pkg::WORD_W-1:0] write_word,
  output logic input_ready,
  input wire logic shift_out,
  output logic output_valid_flag,
  output logic [efh_pkg::WORD_W-1:0] read_word,
  input wire logic output_enable_n,
  input wire logic slow,
  output int viol
);
  logic [efh_pkg::WORD_W-1:0] q[$];
  logic [efh_pkg::WORD_W-1:0] out_r = 4'h0;
  logic si_d = 1'b0;
  logic so_d = 1'b0;
  logic ov_r = 1'b0;
  int fill = 0;
  int f = 0;
  int dly = 0;
  initial viol = 0;
  // Busy while strobe high, low when full, high in clear; flags face the host directly
  assign input_ready = master_clear | (!shift_in & (fill < efh_pkg::DEPTH));
  assign output_valid_flag = ov_r & !master_clear;
  // Released outputs show the inverse word, not the last one
  assign read_word = output_enable_n ? ~out_r : out_r;
  // Fill is registered so the ready flag never moves inside the host's sampling step
  always @(posedge sys_clk) begin
    so_d <= shift_out;
    if (master_clear) begin
      q.delete();
      fill <= 0;
      ov_r <= 1'b0;
      dly <= 0;
      si_d <= 1'b0;
    end else begin
      si_d <= shift_in;
      f = fill;
      if (shift_in && !si_d) begin
        if (f >= efh_pkg::DEPTH) viol++;
        else begin
          q.push_back(write_word);
          f++;
        end
      end
      if (!shift_out && so_d) begin
        if (!ov_r) viol++;
        ov_r <= 1'b0;
        f--;
        dly <= slow ? 6 : 1;
      end else if (!ov_r && q.size() > 0) begin
        if (dly > 0) dly <= dly - 1;
        else begin
          out_r <= q.pop_front();
          ov_r <= 1'b1;
        end
      end
      fill <= f;
    end
  end
endmodule : efh_dev_model
`default_nettype wire

// file: efh_host.sv
// Host controller that drives an external elastic FIFO through its pins.
// Assumes device pins are synchronous to sys_clk and one device is attached.
`timescale 1ns/1ns
`default_nettype none
module efh_host #(
  parameter int WORD_W = efh_pkg::WORD_W,
  parameter int BUF_DEPTH = efh_pkg::DEPTH
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic wr_valid,
  input wire logic [WORD_W-1:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  output logic [WORD_W-1:0] rd_data,
  input wire logic rd_ready,
  output logic master_clear,
  output logic shift_in,
  output logic [WORD_W-1:0] write_word,
  input wire logic input_ready,
  output logic shift_out,
  input wire logic output_valid_flag,
  input wire logic [WORD_W-1:0] read_word,
  output logic output_enable_n
);
  localparam logic [efh_pkg::TMR_W-1:0] T_MC = efh_pkg::TMR_W'(efh_pkg::MCLR_HIGH_CYC);
  localparam logic [efh_pkg::TMR_W-1:0] T_MR = efh_pkg::TMR_W'(efh_pkg::MCLR_RECOV_CYC);
  localparam logic [efh_pkg::TMR_W-1:0] T_HI = efh_pkg::TMR_W'(efh_pkg::STROBE_HIGH_CYC);
  localparam logic [efh_pkg::TMR_W-1:0] T_LO = efh_pkg::TMR_W'(efh_pkg::STROBE_LOW_CYC);

  efh_stream_if #(.W(WORD_W)) tx_in ();
  efh_stream_if #(.W(WORD_W)) tx_out ();
  efh_stream_if #(.W(WORD_W)) rx_in ();
  efh_stream_if #(.W(WORD_W)) rx_out ();

  efh_buf #(.WIDTH(WORD_W), .DEPTH(BUF_DEPTH)) u_tx_buf (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_s(tx_in),
    .out_s(tx_out)
  );

  efh_buf #(.WIDTH(WORD_W), .DEPTH(BUF_DEPTH)) u_rx_buf (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_s(rx_in),
    .out_s(rx_out)
  );

  assign tx_in.valid = wr_valid;
  assign tx_in.data = wr_data;
  assign wr_ready = tx_in.ready;
  assign rd_valid = rx_out.valid;
  assign rd_data = rx_out.data;
  assign rx_out.ready = rd_ready;

  // Power-up clear sequence
  efh_pkg::efh_init_t init_r, init_nxt;
  logic [efh_pkg::TMR_W-1:0] itmr_r, itmr_nxt;
  logic mclr_r, mclr_nxt, oen_r, oen_nxt;
  logic run;

  assign run = (init_r == efh_pkg::EFH_I_RUN);
  assign master_clear = mclr_r;
  assign output_enable_n = oen_r;

  always_comb begin
    init_nxt = init_r;
    itmr_nxt = itmr_r;
    mclr_nxt = mclr_r;
    oen_nxt = oen_r;
    case (init_r)
      efh_pkg::EFH_I_CLEAR: begin
        if (itmr_r <= 1) begin // RULE7
          mclr_nxt = 1'b0;
          itmr_nxt = T_MR;
          init_nxt = efh_pkg::EFH_I_RECOV;
        end else begin
          itmr_nxt = itmr_r - 1'b1;
        end
      end
      efh_pkg::EFH_I_RECOV: begin
        if (itmr_r <= 1) begin
          oen_nxt = 1'b0; // RULE18
          init_nxt = efh_pkg::EFH_I_RUN;
        end else begin
          itmr_nxt = itmr_r - 1'b1;
        end
      end
      efh_pkg::EFH_I_RUN: begin
        init_nxt = efh_pkg::EFH_I_RUN;
      end
      default: begin
        init_nxt = efh_pkg::EFH_I_CLEAR;
        itmr_nxt = T_MC;
        mclr_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      init_r <= efh_pkg::EFH_I_CLEAR;
      itmr_r <= T_MC;
      mclr_r <= 1'b1; // RULE7
      oen_r <= 1'b1;
    end else begin
      init_r <= init_nxt;
      itmr_r <= itmr_nxt;
      mclr_r <= mclr_nxt;
      oen_r <= oen_nxt;
    end
  end

  // Write side: one flag-paced shift-in per word
  efh_pkg::efh_wr_t wst_r, wst_nxt;
  logic [efh_pkg::TMR_W-1:0] wtmr_r, wtmr_nxt;
  logic si_r, si_nxt;
  logic [WORD_W-1:0] ww_r, ww_nxt;

  assign shift_in = si_r;
  assign write_word = ww_r;
  // Single device, so its own flag is the composite flag
  assign tx_out.ready = (wst_r == efh_pkg::EFH_W_IDLE) && run && input_ready; // RULE21 RULE19

  always_comb begin
    wst_nxt = wst_r;
    wtmr_nxt = wtmr_r;
    si_nxt = si_r;
    ww_nxt = ww_r;
    case (wst_r)
      efh_pkg::EFH_W_IDLE: begin
        if (tx_out.ready && tx_out.valid) begin
          ww_nxt = tx_out.data;
          wst_nxt = efh_pkg::EFH_W_SETUP;
        end
      end
      efh_pkg::EFH_W_SETUP: begin
        si_nxt = 1'b1;
        wtmr_nxt = T_HI;
        wst_nxt = efh_pkg::EFH_W_HIGH;
      end
      efh_pkg::EFH_W_HIGH: begin
        if (wtmr_r <= 1) begin
          si_nxt = 1'b0; // RULE13
          wtmr_nxt = T_LO;
          wst_nxt = efh_pkg::EFH_W_LOW;
        end else begin
          wtmr_nxt = wtmr_r - 1'b1;
        end
      end
      efh_pkg::EFH_W_LOW: begin
        if (wtmr_r <= 1) begin
          wst_nxt = efh_pkg::EFH_W_IDLE;
        end else begin
          wtmr_nxt = wtmr_r - 1'b1;
        end
      end
      default: begin
        wst_nxt = efh_pkg::EFH_W_IDLE;
        si_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wst_r <= efh_pkg::EFH_W_IDLE;
      wtmr_r <= '0;
      si_r <= 1'b0;
      ww_r <= '0;
    end else begin
      wst_r <= wst_nxt;
      wtmr_r <= wtmr_nxt;
      si_r <= si_nxt;
      ww_r <= ww_nxt;
    end
  end

  // Read side: capture word, then pulse shift-out
  efh_pkg::efh_rd_t rst_r, rst_nxt;
  logic [efh_pkg::TMR_W-1:0] rtmr_r, rtmr_nxt;
  logic so_r, so_nxt;
  logic take;

  assign shift_out = so_r;
  assign take = (rst_r == efh_pkg::EFH_R_IDLE) && run && output_valid_flag && rx_in.ready; // RULE17
  assign rx_in.valid = take;
  assign rx_in.data = read_word;

  always_comb begin
    rst_nxt = rst_r;
    rtmr_nxt = rtmr_r;
    so_nxt = so_r;
    case (rst_r)
      efh_pkg::EFH_R_IDLE: begin
        if (take) begin
          so_nxt = 1'b1;
          rtmr_nxt = T_HI;
          rst_nxt = efh_pkg::EFH_R_HIGH;
        end
      end
      efh_pkg::EFH_R_HIGH: begin
        if (rtmr_r <= 1) begin
          so_nxt = 1'b0; // RULE17
          rtmr_nxt = T_LO;
          rst_nxt = efh_pkg::EFH_R_LOW;
        end else begin
          rtmr_nxt = rtmr_r - 1'b1;
        end
      end
      efh_pkg::EFH_R_LOW: begin
        if (rtmr_r <= 1) begin
          rst_nxt = efh_pkg::EFH_R_IDLE;
        end else begin
          rtmr_nxt = rtmr_r - 1'b1;
        end
      end
      default: begin
        rst_nxt = efh_pkg::EFH_R_IDLE;
        so_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_r <= efh_pkg::EFH_R_IDLE;
      rtmr_r <= '0;
      so_r <= 1'b0;
    end else begin
      rst_r <= rst_nxt;
      rtmr_r <= rtmr_nxt;
      so_r <= so_nxt;
    end
  end

  property p_no_strobe_before_run;
    @(posedge sys_clk) disable iff (!resetn)
      (master_clear || !run) |-> (!si_r && !so_r && oen_r);
  endproperty
  a_no_strobe_before_run: assert property (p_no_strobe_before_run) else $error("Strobe before clear done"); // RULE7

  property p_clear_pulse;
    @(posedge sys_clk) disable iff (!resetn)
      $fell(mclr_r) |-> !mclr_r[*5] ##1 (init_r == efh_pkg::EFH_I_RUN);
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("Clear recovery wrong"); // RULE7

  property p_si_returns_low;
    @(posedge sys_clk) disable iff (!resetn)
      $rose(si_r) |-> si_r[*2] ##1 !si_r[*2];
  endproperty
  a_si_returns_low: assert property (p_si_returns_low) else $error("Shift-in width wrong"); // RULE13

  property p_si_word_stable;
    @(posedge sys_clk) disable iff (!resetn)
      (si_r || $fell(si_r)) |-> $stable(ww_r);
  endproperty
  a_si_word_stable: assert property (p_si_word_stable) else $error("Write word moved"); // RULE13

  property p_si_needs_room;
    @(posedge sys_clk) disable iff (!resetn)
      $rose(si_r) |-> $past(input_ready, 2);
  endproperty
  a_si_needs_room: assert property (p_si_needs_room) else $error("Shift-in without room"); // RULE19

  property p_so_needs_valid;
    @(posedge sys_clk) disable iff (!resetn)
      $rose(so_r) |-> ($past(output_valid_flag) && $past(rx_in.ready));
  endproperty
  a_so_needs_valid: assert property (p_so_needs_valid) else $error("Shift-out on empty"); // RULE17

  property p_so_period;
    @(posedge sys_clk) disable iff (!resetn)
      $rose(so_r) |-> so_r[*2] ##1 !so_r[*2];
  endproperty
  a_so_period: assert property (p_so_period) else $error("Shift-out period too short"); // RULE19
endmodule : efh_host
`default_nettype wire

// file: efh_pkg.sv
// Constants, timing counts and state types for the elastic FIFO host controller.
// Assumes a single 50 MHz clock and pin inputs already synchronous to it.
// What this block does
// RULE1: Device keeps sixteen 4-bit words in order
// RULE2: Each device slot has a full marker
// RULE3: Empty slot copies full predecessor, clears it
// RULE4: Words ripple to output without strobes
// RULE5: Master clear empties device, sets flags
// RULE6: Master clear keeps output stage word
// RULE7: Pulse master clear once before writing
// RULE8: Input ready high only when input slot empty
// RULE9: Output valid high only with valid word
// RULE10: Shift-in rising edge captures write word
// RULE11: Shift-in high during clear loads on release
// RULE12: Input ready drops after shift-in edge
// RULE13: Writer returns shift-in low each write
// RULE14: Full store, held shift-in loads after read; the model counts a shift-in edge on a full store in viol and drops the word
// RULE15: Shift-out falling edge advances next word
// RULE16: Output valid returns high once refilled
// RULE17: Shift-out held high on empty autoreads
// RULE18: Active-low enable drives or floats outputs; the model shows the inverse word instead of floating
// RULE19: Strobes up to 35 MHz, never overflow
// RULE20: All four data lanes behave alike
// RULE21: Side-by-side devices need combined flags
// RULE22: Chained devices handshake without glue logic
// RULE23: Synchronous version detects edges as events
package efh_pkg;
  localparam int WORD_W = 4;
  localparam int DEPTH = 16;
  localparam int CLK_NS = 20;
  localparam int BURST_MHZ = 35;
  localparam int BURST_PERIOD_NS = (1000 + BURST_MHZ - 1) / BURST_MHZ;
  localparam int STROBE_HIGH_NS = 30;
  localparam int STROBE_LOW_NS = 30;
  localparam int MCLR_HIGH_NS = 100;
  localparam int MCLR_RECOV_NS = 100;
  localparam int TMR_W = 8;

  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns2cyc

  localparam int STROBE_HIGH_CYC = ns2cyc(STROBE_HIGH_NS);
  localparam int STROBE_LOW_CYC = ns2cyc(STROBE_LOW_NS);
  localparam int BURST_CYC = ns2cyc(BURST_PERIOD_NS);
  localparam int MCLR_HIGH_CYC = ns2cyc(MCLR_HIGH_NS);
  localparam int MCLR_RECOV_CYC = ns2cyc(MCLR_RECOV_NS);

  typedef enum logic [2:0] {
    EFH_I_CLEAR = 3'h1,
    EFH_I_RECOV = 3'h2,
    EFH_I_RUN = 3'h4
  } efh_init_t;

  typedef enum logic [3:0] {
    EFH_W_IDLE = 4'h1,
    EFH_W_SETUP = 4'h2,
    EFH_W_HIGH = 4'h4,
    EFH_W_LOW = 4'h8
  } efh_wr_t;

  typedef enum logic [2:0] {
    EFH_R_IDLE = 3'h1,
    EFH_R_HIGH = 3'h2,
    EFH_R_LOW = 3'h4
  } efh_rd_t;
endpackage : efh_pkg

// file: efh_stream_if.sv
// Valid/ready word stream between the host controller and its buffers.
// Assumes both ends share sys_clk.
`timescale 1ns/1ns
`default_nettype none
interface efh_stream_if #(parameter int W = 4);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : efh_stream_if
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the host controller against the store model.
// Assumes the model above and the design's package are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: got %0h want %0h", $time, a, b); end end
module tb_top;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic wr_valid = 1'b0;
  logic rd_ready = 1'b0;
  logic slow = 1'b0;
  logic [3:0] wr_data = 4'h0;
  logic wr_ready, rd_valid, master_clear, shift_in, input_ready, shift_out, ovf, oe_n;
  logic [3:0] rd_data, write_word, read_word;
  logic [3:0] exp_q[$];
  logic [3:0] exp_w;
  int fails = 0;
  int total_checks = 0;
  int viol, n_in = 0, n_out = 0, cnt, base;
  efh_host dut (.sys_clk(sys_clk), .resetn(resetn), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready),
    .master_clear(master_clear), .shift_in(shift_in), .write_word(write_word),
    .input_ready(input_ready), .shift_out(shift_out), .output_valid_flag(ovf),
    .read_word(read_word), .output_enable_n(oe_n));
  efh_dev_model dev (.sys_clk(sys_clk), .master_clear(master_clear), .shift_in(shift_in),
    .write_word(write_word), .input_ready(input_ready), .shift_out(shift_out),
    .output_valid_flag(ovf), .read_word(read_word), .output_enable_n(oe_n), .slow(slow),
    .viol(viol));
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // Reference queue of accepted words
  always @(posedge sys_clk) begin
    if (resetn && wr_valid && wr_ready) begin
      exp_q.push_back(wr_data);
      n_in++;
    end
    if (resetn && rd_valid && rd_ready) begin
      n_out++;
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        exp_w = exp_q.pop_front();
        `CHK(rd_data, exp_w)
      end
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  // Offer up to n words within cyc cycles, reader ready rdpct percent
  task automatic run(input int n, input int rdpct, input int cyc);
    int k;
    k = 0;
    repeat (cyc) begin
      @(posedge sys_clk);
      if (wr_valid && wr_ready) k++;
      rd_ready <= ($urandom % 100) < rdpct;
      if (!wr_valid || wr_ready) begin
        wr_valid <= (k < n) && ($urandom % 4 != 0);
        wr_data <= 4'($urandom);
      end
    end
    @(posedge sys_clk);
    wr_valid <= 1'b0;
  endtask : run
  task automatic drain;
    cnt = 0;
    while (n_out != n_in && cnt < 3000) begin
      @(posedge sys_clk);
      rd_ready <= 1'b1;
      cnt++;
    end
    `CHK(n_out, n_in)
  endtask : drain
  initial begin
    #(20 * 30000);
    fails++;
    wrap_up();
  end
  initial begin
    void'($urandom(11421));
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK(master_clear, 1'b1)
    `CHK(oe_n, 1'b1)
    `CHK(wr_ready, 1'b1)
    @(posedge sys_clk);
    resetn <= 1'b1;
    cnt = 0;
    do begin
      @(posedge sys_clk);
      if (master_clear) cnt++;
    end while (master_clear && cnt < 20);
    `CHK(cnt, 5)
    run(40, 50, 400);
    `CHK(oe_n, 1'b0)
    drain();
    base = n_in;
    run(100, 0, 400);
    `CHK(n_in - base, 3 * efh_pkg::DEPTH)
    `CHK(wr_ready, 1'b0)
    `CHK(ovf, 1'b1)
    drain();
    slow <= 1'b1;
    run(30, 70, 600);
    drain();
    slow <= 1'b0;
    run(60, 90, 300);
    drain();
    `CHK(viol, 0)
    `CHK(rd_valid, 1'b0)
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
